// *** ifb_bank.sv ***
// interrupt flag and enable bank: flags 2..4 tail, enables 0 and 1, register port
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "ifb_map.svh"

module ifb_bank (
	// clock and reset
	input  wire logic               ref_clk_i,
	input  wire logic               rst_n_i,
	// register port
	input  wire ifb_pkg::ifb_addr_t addr_i,
	input  wire ifb_pkg::ifb_word_t wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output ifb_pkg::ifb_word_t      rdata_o,
	// peripheral event sources
	input  wire ifb_pkg::ifb_word_t evt_flags_2_i,
	input  wire ifb_pkg::ifb_word_t evt_flags_3_i,
	input  wire ifb_pkg::ifb_word_t evt_flags_4_i,
	// partner registers held elsewhere
	input  wire ifb_pkg::ifb_word_t flags_0_i,
	input  wire ifb_pkg::ifb_word_t flags_1_i,
	input  wire ifb_pkg::ifb_word_t enables_2_i,
	input  wire ifb_pkg::ifb_word_t enables_3_i,
	input  wire ifb_pkg::ifb_word_t enables_4_i,
	// register contents to priority logic
	output ifb_pkg::ifb_word_t      flags_2_o,
	output ifb_pkg::ifb_word_t      flags_3_o,
	output ifb_pkg::ifb_word_t      flags_4_o,
	output ifb_pkg::ifb_word_t      enables_0_o,
	output ifb_pkg::ifb_word_t      enables_1_o,
	// gated requests to the processor
	output ifb_pkg::ifb_word_t      req_0_o,
	output ifb_pkg::ifb_word_t      req_1_o,
	output ifb_pkg::ifb_word_t      req_2_o,
	output ifb_pkg::ifb_word_t      req_3_o,
	output ifb_pkg::ifb_word_t      req_4_o,
	// block interrupt
	output logic                    irq_o
);

	// address hit on a given offset
	function automatic logic hit(input ifb_pkg::ifb_addr_t a, input ifb_pkg::ifb_addr_t off);
		hit = (a == off);
	endfunction : hit

	// address belongs to any register of the bank
	function automatic logic mapped(input ifb_pkg::ifb_addr_t a);
		mapped = hit(a, `IFB_OFF_FLAGS_2) || hit(a, `IFB_OFF_FLAGS_3) ||
			hit(a, `IFB_OFF_FLAGS_4) || hit(a, `IFB_OFF_EN_0) ||
			hit(a, `IFB_OFF_EN_1) || hit(a, `IFB_OFF_IRQ_STAT) ||
			hit(a, `IFB_OFF_IRQ_MASK);
	endfunction : mapped

	// implemented-bit mask of a register, zero for unmapped
	function automatic ifb_pkg::ifb_word_t impl_mask(input ifb_pkg::ifb_addr_t a);
		case (a)
			`IFB_OFF_FLAGS_2:  impl_mask = `IFB_MASK_FLAGS_2;
			`IFB_OFF_FLAGS_3:  impl_mask = `IFB_MASK_FLAGS_3;
			`IFB_OFF_FLAGS_4:  impl_mask = `IFB_MASK_FLAGS_4;
			`IFB_OFF_EN_0:     impl_mask = `IFB_MASK_EN_0;
			`IFB_OFF_EN_1:     impl_mask = `IFB_MASK_EN_1;
			`IFB_OFF_IRQ_STAT: impl_mask = 16'h0007;
			`IFB_OFF_IRQ_MASK: impl_mask = 16'h0007;
			default:           impl_mask = 16'h0000;
		endcase
	endfunction : impl_mask

	ifb_pkg::ifb_word_t flags_2_q;
	ifb_pkg::ifb_word_t flags_3_q;
	ifb_pkg::ifb_word_t flags_4_q;
	ifb_pkg::ifb_word_t en_0_q;
	ifb_pkg::ifb_word_t en_1_q;
	ifb_pkg::ifb_evt_t  evt_stat;
	ifb_pkg::ifb_evt_t  evt_mask;
	ifb_pkg::ifb_evt_t  blk_evt;
	ifb_pkg::ifb_word_t rdata_reg;
	ifb_pkg::ifb_word_t rdata_next;
	ifb_pkg::ifb_word_t rd_mask_reg;
	logic               rd_pend_reg;
	logic               any_req;
	logic               any_req_reg;
	logic               wr_f2;
	logic               wr_f3;
	logic               wr_f4;
	logic               wr_e0;
	logic               wr_e1;

	// write strobes per register
	assign wr_f2 = wr_i && hit(addr_i, `IFB_OFF_FLAGS_2);
	assign wr_f3 = wr_i && hit(addr_i, `IFB_OFF_FLAGS_3);
	assign wr_f4 = wr_i && hit(addr_i, `IFB_OFF_FLAGS_4);
	assign wr_e0 = wr_i && hit(addr_i, `IFB_OFF_EN_0);
	assign wr_e1 = wr_i && hit(addr_i, `IFB_OFF_EN_1);

	// flags 2 tail: can1 rx, spi2 event, spi2 error
	ifb_bit_reg #(
		.IMPL_MASK (`IFB_MASK_FLAGS_2)
	) u_flags_2 (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (wr_f2),
		.wdata_i   (wdata_i),
		.set_i     (evt_flags_2_i),
		.q_o       (flags_2_q)
	);

	// flags 3: fault a, dma5, encoder, pwm, can2 and low byte sources
	ifb_bit_reg #(
		.IMPL_MASK (`IFB_MASK_FLAGS_3)
	) u_flags_3 (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (wr_f3),
		.wdata_i   (wdata_i),
		.set_i     (evt_flags_3_i),
		.q_o       (flags_3_q)
	);

	// flags 4: can tx requests, dma6/7, uart errors, fault b
	ifb_bit_reg #(
		.IMPL_MASK (`IFB_MASK_FLAGS_4)
	) u_flags_4 (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (wr_f4),
		.wdata_i   (wdata_i),
		.set_i     (evt_flags_4_i),
		.q_o       (flags_4_q)
	);

	// enables 0: software only, no hardware set
	ifb_bit_reg #(
		.IMPL_MASK (`IFB_MASK_EN_0)
	) u_en_0 (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (wr_e0),
		.wdata_i   (wdata_i),
		.set_i     (16'h0000),
		.q_o       (en_0_q)
	);

	// enables 1: software only, bit 2 absent
	ifb_bit_reg #(
		.IMPL_MASK (`IFB_MASK_EN_1)
	) u_en_1 (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (wr_e1),
		.wdata_i   (wdata_i),
		.set_i     (16'h0000),
		.q_o       (en_1_q)
	);

	// register contents out to priority logic
	assign flags_2_o   = flags_2_q;
	assign flags_3_o   = flags_3_q;
	assign flags_4_o   = flags_4_q;
	assign enables_0_o = en_0_q;
	assign enables_1_o = en_1_q;

	// request only while flag and its enable are both set
	assign req_0_o = flags_0_i & en_0_q;
	assign req_1_o = flags_1_i & en_1_q;
	assign req_2_o = flags_2_q & enables_2_i;
	assign req_3_o = flags_3_q & enables_3_i;
	assign req_4_o = flags_4_q & enables_4_i;
	assign any_req = |{req_0_o, req_1_o, req_2_o, req_3_o, req_4_o};

	// request edge tracker
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			any_req_reg <= 1'b0;
		end else begin
			any_req_reg <= any_req;
		end
	end

	// block events: hardware set, new request, access to a hole
	always_comb begin
		blk_evt = '0;
		blk_evt[`IFB_EVT_HW_SET] = |((evt_flags_2_i & `IFB_MASK_FLAGS_2) |
			(evt_flags_3_i & `IFB_MASK_FLAGS_3) | (evt_flags_4_i & `IFB_MASK_FLAGS_4));
		blk_evt[`IFB_EVT_REQ_RISE] = any_req && !any_req_reg;
		blk_evt[`IFB_EVT_BAD_ADDR] = (wr_i || rd_i) && !mapped(addr_i);
	end

	// sticky status, mask and interrupt line
	ifb_evt_irq #(
		.N         (`IFB_EVT_N)
	) u_evt_irq (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.evt_i     (blk_evt),
		.wr_stat_i (wr_i && hit(addr_i, `IFB_OFF_IRQ_STAT)),
		.wr_mask_i (wr_i && hit(addr_i, `IFB_OFF_IRQ_MASK)),
		.wdata_i   (wdata_i[2:0]),
		.stat_o    (evt_stat),
		.mask_o    (evt_mask),
		.irq_o     (irq_o)
	);

	// read multiplexer, holes and absent bits read zero
	always_comb begin
		case (addr_i)
			`IFB_OFF_FLAGS_2:  rdata_next = flags_2_q;
			`IFB_OFF_FLAGS_3:  rdata_next = flags_3_q;
			`IFB_OFF_FLAGS_4:  rdata_next = flags_4_q;
			`IFB_OFF_EN_0:     rdata_next = en_0_q;
			`IFB_OFF_EN_1:     rdata_next = en_1_q;
			`IFB_OFF_IRQ_STAT: rdata_next = {13'h0000, evt_stat};
			`IFB_OFF_IRQ_MASK: rdata_next = {13'h0000, evt_mask};
			default:           rdata_next = 16'h0000;
		endcase
		rdata_next = rdata_next & impl_mask(addr_i);
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= `IFB_RST_VAL;
		end else if (rd_i) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	// read flag and mask of the previous cycle's address, only checked by the assertions
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rd_pend_reg <= 1'b0;
			rd_mask_reg <= 16'h0000;
		end else begin
			rd_pend_reg <= rd_i;
			rd_mask_reg <= impl_mask(addr_i);
		end
	end

	assign rdata_o = rdata_reg;

	// checks

	// event on flags 3 shows in the register next cycle
	a_flag3_event_set: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		((evt_flags_3_i & `IFB_MASK_FLAGS_3) != 16'h0000)
		|=> ((flags_3_q & $past(evt_flags_3_i & `IFB_MASK_FLAGS_3))
			== $past(evt_flags_3_i & `IFB_MASK_FLAGS_3)))
		else $error("flags 3 event did not set its bit");

	// flags 4 holes never set, even under events and writes
	a_flag4_holes_zero: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_f4 || (evt_flags_4_i != 16'h0000))
		|=> ((flags_4_q & ~(`IFB_MASK_FLAGS_4)) == 16'h0000))
		else $error("flags 4 unimplemented bit set");

	// flags 2 tail written then read back
	a_flag2_write_read: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_f2 && (evt_flags_2_i == 16'h0000)) ##1 (rd_i && hit(addr_i, `IFB_OFF_FLAGS_2)
			&& (evt_flags_2_i == 16'h0000))
		|=> (rdata_o == ($past(wdata_i, 2) & `IFB_MASK_FLAGS_2)))
		else $error("flags 2 readback wrong");

	// enables 0 takes written value, bit 15 dropped
	a_en0_write: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_e0 |=> (enables_0_o == ($past(wdata_i) & 16'h7fff)))
		else $error("enables 0 write wrong");

	// enables 1 takes written value, bit 2 dropped, then holds
	a_en1_write_hold: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_e1 ##1 !wr_e1 |=> (enables_1_o == ($past(wdata_i, 2) & 16'hfffb)))
		else $error("enables 1 write or hold wrong");

	// read data never shows an absent bit
	a_read_holes_zero: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		rd_pend_reg |-> ((rdata_o & ~rd_mask_reg) == 16'h0000))
		else $error("unimplemented bit read as one");

	// everything zero right after reset release
	a_reset_clears: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> (flags_2_o == 16'h0000 && flags_3_o == 16'h0000 &&
			flags_4_o == 16'h0000 && enables_0_o == 16'h0000 &&
			enables_1_o == 16'h0000 && rdata_o == 16'h0000 && !irq_o))
		else $error("register not zero after reset");

	// enabled event reaches the request within one cycle
	a_req_gate: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(evt_flags_3_i[`IFB_F3_T7] && !wr_f3) ##1 enables_3_i[`IFB_F3_T7]
		|-> req_3_o[`IFB_F3_T7])
		else $error("enabled flag gave no request");

	// a disabled source never requests
	a_req_blocked: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!enables_4_i[`IFB_F4_FAULT_B] |-> !req_4_o[`IFB_F4_FAULT_B])
		else $error("request while disabled");

	// hardware set beats a software clear in the same cycle
	a_set_beats_clear: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_f3 && !wdata_i[`IFB_F3_T7] && evt_flags_3_i[`IFB_F3_T7])
		|=> flags_3_o[`IFB_F3_T7])
		else $error("software clear beat hardware set");

	// write of zero with no event clears the flag
	a_sw_clear: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_f4 && !wdata_i[`IFB_F4_DMA7] && !evt_flags_4_i[`IFB_F4_DMA7])
		|=> !flags_4_o[`IFB_F4_DMA7])
		else $error("software clear ignored");

	// interrupt follows an unmasked access to a hole in the next cycle
	a_irq_bad_addr: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		((wr_i || rd_i) && !mapped(addr_i) && evt_mask[`IFB_EVT_BAD_ADDR]) ##1
			!(wr_i && hit(addr_i, `IFB_OFF_IRQ_MASK))
		|-> irq_o)
		else $error("hole access raised no interrupt");

	// flags 3 holds with no write and no event
	a_flag3_hold: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(!wr_f3 && (evt_flags_3_i == 16'h0000))
		|=> (flags_3_q == $past(flags_3_q)))
		else $error("flags 3 changed with no cause");

	// enable holes stay zero after any enable write
	a_en_holes_zero: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_e0 || wr_e1)
		|=> (!enables_0_o[15] && !enables_1_o[2]))
		else $error("enable hole set");

	// flags 2 holds nothing above its three tail bits
	a_flag2_tail_only: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_f2 || (evt_flags_2_i != 16'h0000))
		|=> ((flags_2_q & ~(`IFB_MASK_FLAGS_2)) == 16'h0000))
		else $error("flags 2 bit above tail set");

	// a new request marks its status bit next cycle
	a_req_rise_mark: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(any_req && !any_req_reg) |=> evt_stat[`IFB_EVT_REQ_RISE])
		else $error("request rise not recorded");

	// read data rests at zero when no read was made
	a_rdata_idle: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!rd_i |=> (rdata_o == 16'h0000))
		else $error("read data not idle");

endmodule : ifb_bank

// *** ifb_bit_reg.sv ***
// one 16-bit flag or enable register with hardware set and software write
`timescale 1ns/1ps
`include "ifb_map.svh"

module ifb_bit_reg #(
	parameter logic [15:0] IMPL_MASK = 16'hffff
) (
	// clock and reset
	input  wire logic           ref_clk_i,
	input  wire logic           rst_n_i,
	// software write
	input  wire logic           wr_i,
	input  wire ifb_pkg::ifb_word_t wdata_i,
	// hardware set
	input  wire ifb_pkg::ifb_word_t set_i,
	// stored value
	output ifb_pkg::ifb_word_t  q_o
);
	ifb_pkg::ifb_word_t bits_reg;
	ifb_pkg::ifb_word_t bits_next;

	// write replaces, hardware set ORs on top so it wins over a clear
	always_comb begin
		bits_next = wr_i ? wdata_i : bits_reg;
		bits_next = (bits_next | set_i) & IMPL_MASK;
	end

	// storage, zero after reset
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bits_reg <= `IFB_RST_VAL;
		end else begin
			bits_reg <= bits_next;
		end
	end

	assign q_o = bits_reg;
endmodule : ifb_bit_reg

// *** ifb_evt_irq.sv ***
// sticky block event status, mask and level interrupt
`timescale 1ns/1ps
`include "ifb_map.svh"

module ifb_evt_irq #(
	parameter int N = 3
) (
	// clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	// events and software access
	input  wire logic [N-1:0] evt_i,
	input  wire logic         wr_stat_i,
	input  wire logic         wr_mask_i,
	input  wire logic [N-1:0] wdata_i,
	// state and interrupt
	output logic [N-1:0]      stat_o,
	output logic [N-1:0]      mask_o,
	output logic              irq_o
);
	logic [N-1:0] stat_reg;
	logic [N-1:0] mask_reg;

	// write one to clear; a new event in the same cycle stays set
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~(wr_stat_i ? wdata_i : '0)) | evt_i;
		end
	end

	// mask, one enables the status bit onto the interrupt
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mask_reg <= '0;
		end else if (wr_mask_i) begin
			mask_reg <= wdata_i;
		end
	end

	assign stat_o = stat_reg;
	assign mask_o = mask_reg;
	assign irq_o  = |(stat_reg & mask_reg);
endmodule : ifb_evt_irq

// *** ifb_map.svh ***
// register offsets, field masks and reset values of the interrupt flag and enable bank
// Function
// - flags3: fault A, DMA5, encoder, PWM, CAN2
// - flags3 low byte: eight listed source flags
// - flags4: high byte and bit3 absent
// - flags2 bits 2..0: CAN1 rx, SPI2
// - enables0 high: bit15 absent, seven enables
// - enables0 low byte: eight listed enables
// - enables1 high byte: eight listed enables
// - enables1 low byte, bit2 absent
// - absent bits read zero, ignore writes
// - implemented bits read/write, zero after reset
`ifndef IFB_MAP_SVH
`define IFB_MAP_SVH

// data and address widths
`define IFB_DW           16
`define IFB_AW           4

// register offsets (word index on the register port)
`define IFB_OFF_FLAGS_2  4'h0
`define IFB_OFF_FLAGS_3  4'h1
`define IFB_OFF_FLAGS_4  4'h2
`define IFB_OFF_EN_0     4'h3
`define IFB_OFF_EN_1     4'h4
`define IFB_OFF_IRQ_STAT 4'h5
`define IFB_OFF_IRQ_MASK 4'h6

// implemented bits of each register
`define IFB_MASK_FLAGS_2 16'h0007
`define IFB_MASK_FLAGS_3 16'ha7ff
`define IFB_MASK_FLAGS_4 16'h00f7
`define IFB_MASK_EN_0    16'h7fff
`define IFB_MASK_EN_1    16'hfffb

// reset value of every register
`define IFB_RST_VAL      16'h0000

// flags 2 fields
`define IFB_F2_CAN1_RX   2
`define IFB_F2_SPI2_EVT  1
`define IFB_F2_SPI2_ERR  0
// flags 3 fields
`define IFB_F3_FAULT_A   15
`define IFB_F3_DMA5      13
`define IFB_F3_ENCODER   10
`define IFB_F3_PWM_ERR   9
`define IFB_F3_CAN2_EVT  8
`define IFB_F3_CAN2_RX   7
`define IFB_F3_T7        0
// flags 4 fields
`define IFB_F4_CAN2_TX   7
`define IFB_F4_CAN1_TX   6
`define IFB_F4_DMA7      5
`define IFB_F4_DMA6      4
`define IFB_F4_UART2_ERR 2
`define IFB_F4_UART1_ERR 1
`define IFB_F4_FAULT_B   0
// enables 0 and 1 selected fields
`define IFB_E0_DMA1      14
`define IFB_E0_ADC1      13
`define IFB_E0_EXT0      0
`define IFB_E1_ADC2      5
`define IFB_E1_CHANGE    3

// block event status bits
`define IFB_EVT_N        3
`define IFB_EVT_HW_SET   0
`define IFB_EVT_REQ_RISE 1
`define IFB_EVT_BAD_ADDR 2

`endif

// *** ifb_pkg.sv ***
// types shared by the interrupt flag and enable bank
package ifb_pkg;
	typedef logic [15:0] ifb_word_t;
	typedef logic [3:0]  ifb_addr_t;
	typedef logic [2:0]  ifb_evt_t;
endpackage : ifb_pkg

// *** ifb_src_model.sv ***
// stand-in for the peripheral event sources and the neighbouring flag and enable registers
`timescale 1ns/1ps

module ifb_src_model (
	// clock
	input  wire logic          ref_clk_i,
	// peripheral event lines
	output ifb_pkg::ifb_word_t evt_flags_2_o,
	output ifb_pkg::ifb_word_t evt_flags_3_o,
	output ifb_pkg::ifb_word_t evt_flags_4_o,
	// neighbouring registers held outside the bank
	output ifb_pkg::ifb_word_t flags_0_o,
	output ifb_pkg::ifb_word_t flags_1_o,
	output ifb_pkg::ifb_word_t enables_2_o,
	output ifb_pkg::ifb_word_t enables_3_o,
	output ifb_pkg::ifb_word_t enables_4_o
);
	// quiet sources at time zero
	initial begin
		{evt_flags_2_o, evt_flags_3_o, evt_flags_4_o} = '0;
		{flags_0_o, flags_1_o, enables_2_o, enables_3_o, enables_4_o} = '0;
	end

	// event levels change just after an edge; a held level keeps setting its flag
	task automatic set_evt(input ifb_pkg::ifb_word_t w2, w3, w4);
		@(posedge ref_clk_i);
		evt_flags_2_o <= w2;
		evt_flags_3_o <= w3;
		evt_flags_4_o <= w4;
	endtask : set_evt

	// levels of the registers that live next to the bank
	task automatic set_ext(input ifb_pkg::ifb_word_t f0, f1, e2, e3, e4);
		@(posedge ref_clk_i);
		flags_0_o   <= f0;
		flags_1_o   <= f1;
		enables_2_o <= e2;
		enables_3_o <= e3;
		enables_4_o <= e4;
	endtask : set_ext
endmodule : ifb_src_model

// *** tb.sv ***
// self-checking testbench of the interrupt flag and enable bank
`timescale 1ns/1ps
`include "ifb_map.svh"

module tb;
	// clock, reset and register port
	logic               ref_clk_i = 1'b0;
	logic               rst_n_i   = 1'b0;
	ifb_pkg::ifb_addr_t addr_i    = 4'h0;
	ifb_pkg::ifb_word_t wdata_i   = 16'h0000;
	logic               wr_i      = 1'b0;
	logic               rd_i      = 1'b0;
	ifb_pkg::ifb_word_t rdata_o;
	logic               irq_o;
	// partner lines and bank outputs
	ifb_pkg::ifb_word_t ev2, ev3, ev4, f0, f1, e2, e3, e4;
	ifb_pkg::ifb_word_t fl2, fl3, fl4, en0, en1, rq0, rq1, rq2, rq3, rq4;
	int                 err_count = 0;
	int                 n_tests   = 0;
	int                 cycles    = 0;
	ifb_pkg::ifb_word_t v;
	ifb_pkg::ifb_word_t masks [5] = '{`IFB_MASK_FLAGS_2, `IFB_MASK_FLAGS_3, `IFB_MASK_FLAGS_4,
		`IFB_MASK_EN_0, `IFB_MASK_EN_1};

	// 25 MHz clock
	always #20 ref_clk_i = ~ref_clk_i;

	ifb_src_model ifb_src_model_inst (.ref_clk_i(ref_clk_i), .evt_flags_2_o(ev2),
		.evt_flags_3_o(ev3), .evt_flags_4_o(ev4), .flags_0_o(f0), .flags_1_o(f1),
		.enables_2_o(e2), .enables_3_o(e3), .enables_4_o(e4));

	ifb_bank ifb_bank_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.evt_flags_2_i(ev2), .evt_flags_3_i(ev3), .evt_flags_4_i(ev4),
		.flags_0_i(f0), .flags_1_i(f1), .enables_2_i(e2), .enables_3_i(e3),
		.enables_4_i(e4), .flags_2_o(fl2), .flags_3_o(fl3), .flags_4_o(fl4),
		.enables_0_o(en0), .enables_1_o(en1), .req_0_o(rq0), .req_1_o(rq1),
		.req_2_o(rq2), .req_3_o(rq3), .req_4_o(rq4), .irq_o(irq_o));

	// verdict and end of run
	task automatic close_out();
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// one comparison
	task automatic chk(input string name, input ifb_pkg::ifb_word_t got, exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr_reg(input ifb_pkg::ifb_addr_t a, input ifb_pkg::ifb_word_t d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
		#1;
	endtask : wr_reg

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_reg(input ifb_pkg::ifb_addr_t a, output ifb_pkg::ifb_word_t d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd_reg

	// the five flag and enable registers, irq and requests are zero out of reset
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rd_reg(4'(i), v);
			chk("reset value", v, 16'h0000);
		end
		chk("reset irq", {15'h0000, irq_o}, 16'h0000);
		chk("reset req", rq0 | rq1 | rq2 | rq3 | rq4, 16'h0000);
		@(posedge ref_clk_i);
		#1;
		chk("read data idle", rdata_o, 16'h0000);
	endtask : t_reset

	// all-ones then zero: only implemented bits stick
	task automatic t_rw();
		for (int i = 0; i < 5; i++) begin
			wr_reg(4'(i), 16'hffff);
			rd_reg(4'(i), v);
			chk("ones readback", v, masks[i]);
			wr_reg(4'(i), 16'h0000);
			rd_reg(4'(i), v);
			chk("zero readback", v, 16'h0000);
		end
	endtask : t_rw

	// write then read on the next cycle, no gap between strobes
	task automatic t_b2b();
		@(posedge ref_clk_i);
		addr_i  <= `IFB_OFF_FLAGS_2;
		wdata_i <= 16'h0005;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
		rd_i    <= 1'b1;
		@(posedge ref_clk_i);
		rd_i    <= 1'b0;
		#1;
		chk("back to back read", rdata_o, 16'h0005);
		wr_reg(`IFB_OFF_FLAGS_2, 16'h0000);
	endtask : t_b2b

	// hardware sets flags regardless of enables; requests need both bits
	task automatic t_events();
		ifb_src_model_inst.set_evt(16'hffff, 16'hffff, 16'hffff);
		ifb_src_model_inst.set_evt(16'h0000, 16'h0000, 16'h0000);
		#1;
		chk("flags 2 set", fl2, 16'h0007);
		chk("flags 3 set", fl3, 16'ha7ff);
		chk("flags 4 set", fl4, 16'h00f7);
		chk("req 3 gated", rq3, 16'h0000);
		ifb_src_model_inst.set_ext(16'hffff, 16'hffff, 16'h0000, 16'h8001, 16'h0080);
		#1;
		chk("req 2 gated", rq2, 16'h0000);
		chk("req 3 open", rq3, 16'h8001);
		chk("req 4 open", rq4, 16'h0080);
		wr_reg(`IFB_OFF_EN_0, 16'hc001);
		chk("req 0 open", rq0, 16'h4001);
		wr_reg(`IFB_OFF_EN_1, 16'h002c);
		chk("req 1 open", rq1, 16'h0028);
		chk("enables 0 out", en0, 16'h4001);
		chk("enables 1 out", en1, 16'h0028);
		ifb_src_model_inst.set_ext('0, '0, '0, '0, '0);
		for (int i = 0; i < 5; i++)
			wr_reg(4'(i), 16'h0000);
		chk("flags cleared", fl2 | fl3 | fl4, 16'h0000);
		rd_reg(`IFB_OFF_IRQ_STAT, v);
		chk("event status", v, 16'h0003);
	endtask : t_events

	// a set in the same cycle as a software clear wins
	task automatic t_clear();
		ifb_src_model_inst.set_ext('0, '0, '0, 16'h0001, '0);
		ifb_src_model_inst.set_evt(16'h0000, 16'h0001, 16'h0000);
		wr_reg(`IFB_OFF_FLAGS_3, 16'h0000);
		rd_reg(`IFB_OFF_FLAGS_3, v);
		chk("set beats clear", v, 16'h0001);
		chk("req 3 timer 7", rq3, 16'h0001);
		ifb_src_model_inst.set_evt(16'h0000, 16'h0000, 16'h0000);
		wr_reg(`IFB_OFF_FLAGS_3, 16'h0000);
		rd_reg(`IFB_OFF_FLAGS_3, v);
		chk("clear after set", v, 16'h0000);
		chk("req 3 dropped", rq3, 16'h0000);
		ifb_src_model_inst.set_ext('0, '0, '0, '0, '0);
	endtask : t_clear

	// unmapped access reads zero, changes nothing, raises a masked block interrupt
	task automatic t_irq();
		wr_reg(`IFB_OFF_IRQ_STAT, 16'h0007);
		wr_reg(`IFB_OFF_IRQ_MASK, 16'h0004);
		rd_reg(4'h9, v);
		chk("unmapped read", v, 16'h0000);
		for (int i = 0; i < 3 && irq_o !== 1'b1; i++)
			@(posedge ref_clk_i);
		#1;
		chk("irq raised", {15'h0000, irq_o}, 16'h0001);
		wr_reg(`IFB_OFF_IRQ_STAT, 16'h0004);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("irq cleared", {15'h0000, irq_o}, 16'h0000);
		wr_reg(`IFB_OFF_IRQ_MASK, 16'h0000);
		wr_reg(4'h9, 16'hffff);
		rd_reg(`IFB_OFF_IRQ_STAT, v);
		chk("status sticky", v, 16'h0004);
		chk("irq masked", {15'h0000, irq_o}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			rd_reg(4'(i), v);
			chk("unmapped write", v, 16'h0000);
		end
		wr_reg(`IFB_OFF_IRQ_STAT, 16'h0007);
	endtask : t_irq

	// reset in mid-run clears what software and hardware left behind
	task automatic t_reset_again();
		wr_reg(`IFB_OFF_EN_1, 16'hffff);
		ifb_src_model_inst.set_evt(16'h0000, 16'h8000, 16'h0000);
		ifb_src_model_inst.set_evt(16'h0000, 16'h0000, 16'h0000);
		#1;
		chk("flag before reset", fl3, 16'h8000);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk("reset again flags", fl3, 16'h0000);
		chk("reset again enables", en1, 16'h0000);
		chk("reset again irq", {15'h0000, irq_o}, 16'h0000);
		@(posedge ref_clk_i);
		#1;
		chk("reset again read data", rdata_o, 16'h0000);
	endtask : t_reset_again

	// hang guard
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			close_out();
		end
	end

	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_rw();
		t_b2b();
		t_events();
		t_clear();
		t_irq();
		t_reset_again();
		close_out();
	end
endmodule : tb
